// *** cfd_flag_unit.sv ***
`timescale 1ns/1ps
// Operation
// RQ1 - Bit 0 flags binary overflow, or lost digits in zero-add and decimal add/sub.
// RQ2 - Compare sets bit 1 when greater, bit 2 when less, clears bits 0 and 4.
// RQ3 - Decimal results set bit 1 positive, bit 2 negative, bit 3 zero.
// RQ4 - Binary arithmetic sets bit 3 on carry out of the top adder bit.
// RQ5 - Decimal op sets bit 4 on a non-digit byte or a bad sign nibble.
// RQ6 - Compare sets bit 5 greater, bit 6 less, bit 7 equal.
// RQ7 - Compare updates both groups; signedness per compare kind.
// RQ8 - Equal compare sets 3 and 7, clears 0-2 and 4-6, keeps 8-15.
// RQ9 - Storage access outside the state's bounds sets bit 12.
// RQ10 - A service request instruction sets bit 13.
// RQ11 - A storage read parity error sets bit 14.
// RQ12 - Undefined, restricted or foreign-state opcode sets bit 15.
// RQ13 - Writes go in whole 4-bit groups; untouched groups hold.
// RQ14 - Only the specified bits change; bits 8-11 stay reserved.
// RQ15 - Word addresses are even; the low address bit is ignored.
// RQ16 - Byte operand: even address takes upper byte, odd takes lower.
// RQ17 - 16 and 32 bit operands are two's complement, top bit sign.
// RQ18 - Add overflows only with like signs and a changed result sign.
// RQ19 - Subtract overflows only with unlike signs.
// RQ20 - A 32-bit operand is two adjacent words, high word first.
// RQ21 - Zoned digits carry zone F; sign A,C,E,F plus, B,D minus.
// RQ22 - Packing drops zones, sign goes last, even count gets leading zero.
module cfd_flag_unit
  import cfd_pkg::*;
#(
  parameter int unsigned DIGITS = DIGITS_DEF
) (
  input  wire logic                       clk,
  input  wire logic                       reset_n,
  input  wire logic                       op_valid,
  input  wire cfd_op_t                    op_code,
  input  wire logic                       op_double,
  input  wire logic [DWORD_W-1:0]         opnd_a,
  input  wire logic [DWORD_W-1:0]         opnd_b,
  input  wire logic                       div_overflow,
  input  wire logic                       dec_lost,
  input  wire logic [8*DIGITS-1:0]        dec_zoned,
  input  wire logic                       bound_violation,
  input  wire logic                       service_request,
  input  wire logic                       read_parity_error,
  input  wire logic                       illegal_opcode,
  input  wire logic                       flags_load,
  input  wire logic [CF_W-1:0]            flags_load_data,
  input  wire logic [WORD_W-1:0]          mem_addr,
  input  wire logic [WORD_W-1:0]          mem_word,
  output logic      [CF_W-1:0]            condition_flags,
  output logic      [DWORD_W-1:0]         arith_result,
  output logic      [WORD_W-1:0]          word_addr,
  output logic      [BYTE_W-1:0]          byte_operand,
  output logic      [8*(DIGITS/2+1)-1:0]  packed_field
);

  localparam int unsigned PW = 8 * (DIGITS / 2 + 1);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [CF_W-1:0]    flags;
    logic [DWORD_W-1:0] result;
    logic [WORD_W-1:0]  word_addr;
    logic [BYTE_W-1:0]  byte_op;
    logic [PW-1:0]      pack_val;
  } cfd_state_t;

  cfd_state_t st;
  cfd_state_t next_st;

  cfd_dec_if #(.DIGITS(DIGITS)) dec ();

  assign dec.zoned = dec_zoned;

  cfd_zoned_pack #(
    .DIGITS (DIGITS)
  ) u_pack (
    .dec    (dec)
  );

  // ****************************************************************
  // Adder and comparators
  // ****************************************************************
  logic               is_sub;
  logic [DWORD_W:0]   sum_d;
  logic [WORD_W:0]    sum_s;
  logic               sgn_a;
  logic               sgn_b;
  logic               sgn_r;
  logic               carry;
  logic               ovf;
  logic               s_gt;
  logic               s_lt;
  logic               u_gt;
  logic               u_lt;
  logic               eq;
  logic [3:0]         grp_a;
  logic [3:0]         grp_l;
  logic               dec_op;
  logic               is_cmp;

  // Subtract is add of the inverted operand plus one, so carry is the link
  assign is_sub = (op_code == OP_SUB);
  assign sum_d  = {1'b0, opnd_a} + {1'b0, is_sub ? ~opnd_b : opnd_b}
                  + {{DWORD_W{1'b0}}, is_sub};
  assign sum_s  = {1'b0, opnd_a[WORD_W-1:0]}
                  + {1'b0, is_sub ? ~opnd_b[WORD_W-1:0] : opnd_b[WORD_W-1:0]}
                  + {{WORD_W{1'b0}}, is_sub};

  // Double operands hold the high word in the upper half
  always_comb begin
    if (op_double) begin // RQ20
      sgn_a = opnd_a[DWORD_W-1]; // RQ17
      sgn_b = opnd_b[DWORD_W-1];
      sgn_r = sum_d[DWORD_W-1];
      carry = sum_d[DWORD_W];
    end else begin
      sgn_a = opnd_a[WORD_W-1]; // RQ17
      sgn_b = opnd_b[WORD_W-1];
      sgn_r = sum_s[WORD_W-1];
      carry = sum_s[WORD_W];
    end
  end

  // Unlike-signed add and like-signed subtract can never overflow
  assign ovf = is_sub ? ((sgn_a != sgn_b) && (sgn_r != sgn_a))  // RQ19
                      : ((sgn_a == sgn_b) && (sgn_r != sgn_a)); // RQ18

  // Relations per compare kind
  always_comb begin
    case (op_code)
      OP_CMP_BYTE: begin
        s_gt = opnd_a[BYTE_W-1:0] > opnd_b[BYTE_W-1:0]; // RQ7
        s_lt = opnd_a[BYTE_W-1:0] < opnd_b[BYTE_W-1:0];
        u_gt = s_gt;
        u_lt = s_lt;
        eq   = opnd_a[BYTE_W-1:0] == opnd_b[BYTE_W-1:0];
      end
      OP_CMP_SIGNED: begin
        s_gt = $signed(opnd_a) > $signed(opnd_b); // RQ7
        s_lt = $signed(opnd_a) < $signed(opnd_b);
        u_gt = s_gt;
        u_lt = s_lt;
        eq   = opnd_a == opnd_b;
      end
      default: begin
        s_gt = $signed(opnd_a[WORD_W-1:0]) > $signed(opnd_b[WORD_W-1:0]); // RQ7
        s_lt = $signed(opnd_a[WORD_W-1:0]) < $signed(opnd_b[WORD_W-1:0]);
        u_gt = opnd_a[WORD_W-1:0] > opnd_b[WORD_W-1:0];
        u_lt = opnd_a[WORD_W-1:0] < opnd_b[WORD_W-1:0];
        eq   = opnd_a[WORD_W-1:0] == opnd_b[WORD_W-1:0];
      end
    endcase
  end

  assign is_cmp = (op_code == OP_CMP_BYTE) || (op_code == OP_CMP_SIGNED)
                  || (op_code == OP_CMP_WORD);
  assign dec_op = (op_code == OP_ZERO_ADD) || (op_code == OP_DEC_ADD)
                  || (op_code == OP_DEC_SUB);

  // ****************************************************************
  // Group values; index 0 of each group is its lowest bit number
  // ****************************************************************
  always_comb begin
    grp_a = GRP_CLEAR;
    grp_l = GRP_CLEAR;
    if (is_cmp) begin
      // Overflow and bad-digit positions drop on every compare
      grp_a = {eq, s_lt, s_gt, 1'b0}; // RQ2 RQ8
      grp_l = {eq, u_lt, u_gt, 1'b0}; // RQ6 RQ8
    end else if (dec_op) begin
      grp_a = {dec.zero, dec.negative & ~dec.zero,
               ~dec.negative & ~dec.zero, dec_lost}; // RQ1 RQ3
      // Second group mirrors the sign and carries the bad-data mark
      grp_l = {dec.zero, dec.negative & ~dec.zero,
               ~dec.negative & ~dec.zero, dec.invalid}; // RQ5
    end else if (op_code == OP_DIVIDE) begin
      grp_a = {3'b000, div_overflow}; // RQ1
    end else begin
      grp_a = {carry, 2'b00, ovf}; // RQ1 RQ4
    end
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    next_st = st;
    // Restore by the sequencer at a state switch; instruction wins
    if (flags_load) begin
      next_st.flags = flags_load_data;
    end
    if (op_valid) begin
      // Whole groups only; a restore cannot leave a stale half group
      next_st.flags[GRP_ARITH*GRP_W +: GRP_W] = grp_a; // RQ13
      if (is_cmp || dec_op) begin
        next_st.flags[GRP_LOGIC*GRP_W +: GRP_W] = grp_l; // RQ13 RQ14
      end
      if (!is_cmp && !dec_op) begin
        next_st.result = op_double ? sum_d[DWORD_W-1:0]
                                   : {{WORD_W{1'b0}}, sum_s[WORD_W-1:0]};
      end
      if (dec_op) begin
        next_st.pack_val = dec.packed_val; // RQ22
      end
    end
    // Exception events rewrite their group; set beats any restore
    if (bound_violation || service_request || read_parity_error || illegal_opcode) begin
      next_st.flags[CF_BOUND]   = bound_violation;   // RQ9
      next_st.flags[CF_SVC]     = service_request;   // RQ10
      next_st.flags[CF_PARITY]  = read_parity_error; // RQ11
      next_st.flags[CF_ILLEGAL] = illegal_opcode;    // RQ12
    end
    // Reserved group never holds a one
    next_st.flags[GRP_RSVD*GRP_W +: GRP_W] = GRP_CLEAR; // RQ14
    // Low address bit is dropped for words and steers bytes
    next_st.word_addr = {mem_addr[WORD_W-1:1], 1'b0}; // RQ15
    next_st.byte_op   = mem_addr[0] ? mem_word[BYTE_W-1:0]
                                    : mem_word[WORD_W-1:BYTE_W]; // RQ16
  end

  // Single state register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '{flags: CF_RESET, result: '0, word_addr: '0, byte_op: '0, pack_val: '0};
    end else begin
      st <= next_st;
    end
  end

  assign condition_flags = st.flags;
  assign arith_result    = st.result;
  assign word_addr       = st.word_addr;
  assign byte_operand    = st.byte_op;
  assign packed_field    = st.pack_val;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  logic no_evt;
  assign no_evt = !(bound_violation || service_request || read_parity_error || illegal_opcode);

  a_cmp_clears: assert property (op_valid && is_cmp |=> !st.flags[CF_OVF] && !st.flags[CF_BADDEC]) // RQ2
    else $error("compare left bit 0 or 4 set");
  a_cmp_equal: assert property (op_valid && op_code == OP_CMP_WORD
      && opnd_a[WORD_W-1:0] == opnd_b[WORD_W-1:0] && !flags_load
      |=> st.flags[7:0] == 8'h88) // RQ8
    else $error("equal compare pattern wrong");
  a_word_mixed: assert property (op_valid && op_code == OP_CMP_WORD
      && opnd_a[WORD_W-1:0] == 16'h8000 && opnd_b[WORD_W-1:0] == 16'h0001
      |=> st.flags[CF_LT] && st.flags[CF_LGT] && !st.flags[CF_GT]) // RQ7
    else $error("word compare signedness wrong");
  a_add_unlike: assert property (op_valid && op_code == OP_ADD && !op_double
      && opnd_a[WORD_W-1] != opnd_b[WORD_W-1] |=> !st.flags[CF_OVF]) // RQ18
    else $error("unlike add flagged overflow");
  a_add_over: assert property (op_valid && op_code == OP_ADD && !op_double
      && opnd_a[WORD_W-1:0] == 16'h7fff && opnd_b[WORD_W-1:0] == 16'h0001
      |=> st.flags[CF_OVF] && !st.flags[CF_EQ]) // RQ18
    else $error("add overflow missed");
  a_sub_like: assert property (op_valid && op_code == OP_SUB
      && sgn_a == sgn_b |=> !st.flags[CF_OVF]) // RQ19
    else $error("like subtract flagged overflow");
  a_link_carry: assert property (op_valid && op_code == OP_ADD && !op_double
      && opnd_a[WORD_W-1:0] == 16'hffff && opnd_b[WORD_W-1:0] == 16'h0001
      |=> st.flags[CF_EQ] && st.result[WORD_W-1:0] == 16'h0000) // RQ4
    else $error("link bit missed");
  a_dbl_over: assert property (op_valid && op_code == OP_ADD && op_double
      && opnd_a == 32'h7fffffff && opnd_b == 32'h00000001
      |=> st.flags[CF_OVF] && !st.flags[CF_EQ]
          && st.result == 32'h80000000) // RQ20
    else $error("double add overflow missed");
  a_div_ovf: assert property (op_valid && op_code == OP_DIVIDE
      |=> st.flags[GRP_ARITH*GRP_W +: GRP_W] == {3'b000, $past(div_overflow)}) // RQ1
    else $error("divide overflow bit wrong");
  a_dec_bad: assert property (op_valid && dec_op && dec.invalid
      |=> st.flags[CF_BADDEC]) // RQ5
    else $error("bad decimal not flagged");
  a_dec_zero: assert property (op_valid && op_code == OP_DEC_ADD && dec.zero && !dec_lost
      |=> st.flags[3:0] == 4'h8) // RQ3
    else $error("decimal zero pattern wrong");
  a_svc_bit: assert property (service_request |=> st.flags[CF_SVC]) // RQ10
    else $error("service request not flagged");
  a_exc_bits: assert property (bound_violation || read_parity_error || illegal_opcode
      |=> st.flags[CF_BOUND] == $past(bound_violation)
          && st.flags[CF_PARITY] == $past(read_parity_error)
          && st.flags[CF_ILLEGAL] == $past(illegal_opcode)) // RQ9 RQ11 RQ12
    else $error("exception bits wrong");
  a_hold_groups: assert property (!op_valid && !flags_load && no_evt
      [*2] |-> $stable(st.flags)) // RQ13 RQ14
    else $error("flags changed without cause");
  a_rsvd_zero: assert property (st.flags[GRP_RSVD*GRP_W +: GRP_W] == GRP_CLEAR) // RQ14
    else $error("reserved bits set");
  a_byte_pick: assert property (##1 st.byte_op == ($past(mem_addr[0])
      ? $past(mem_word[7:0]) : $past(mem_word[15:8]))) // RQ16
    else $error("byte select wrong");
  a_word_even: assert property (st.word_addr[0] == 1'b0) // RQ15
    else $error("odd word address");

  c_cmp_eq:   cover property (op_valid && is_cmp ##1 st.flags[CF_EQ] && st.flags[CF_LEQ]);
  c_add_ovf:  cover property (op_valid && op_code == OP_ADD ##1 st.flags[CF_OVF]);
  c_dec_neg:  cover property (op_valid && dec_op ##1 st.flags[CF_LT]);
  c_exc:      cover property (illegal_opcode ##1 st.flags[CF_ILLEGAL]);
  c_dbl_add:  cover property (op_valid && op_double ##1 st.flags[CF_OVF]);

endmodule : cfd_flag_unit

// *** cfd_pkg.sv ***
package cfd_pkg;

  // ****************************************************************
  // Condition register layout (index n holds condition bit n)
  // ****************************************************************
  localparam int unsigned CF_W       = 16;
  localparam int unsigned GRP_W      = 4;
  localparam int unsigned GRP_ARITH  = 0;  // Bits 0-3
  localparam int unsigned GRP_LOGIC  = 1;  // Bits 4-7
  localparam int unsigned GRP_RSVD   = 2;  // Bits 8-11
  localparam int unsigned GRP_EXC    = 3;  // Bits 12-15
  localparam int unsigned CF_OVF     = 0;
  localparam int unsigned CF_GT      = 1;
  localparam int unsigned CF_LT      = 2;
  localparam int unsigned CF_EQ      = 3;
  localparam int unsigned CF_BADDEC  = 4;
  localparam int unsigned CF_LGT     = 5;
  localparam int unsigned CF_LLT     = 6;
  localparam int unsigned CF_LEQ     = 7;
  localparam int unsigned CF_BOUND   = 12;
  localparam int unsigned CF_SVC     = 13;
  localparam int unsigned CF_PARITY  = 14;
  localparam int unsigned CF_ILLEGAL = 15;
  localparam logic [15:0] CF_RESET   = 16'h0000;
  localparam logic [3:0]  GRP_CLEAR  = 4'h0;

  // ****************************************************************
  // Data formats
  // ****************************************************************
  localparam int unsigned WORD_W     = 16;
  localparam int unsigned DWORD_W    = 32;
  localparam int unsigned BYTE_W     = 8;
  localparam int unsigned NIB_W      = 4;
  localparam int unsigned DIGITS_DEF = 5;
  localparam logic [3:0]  ZONE_NIB   = 4'hf;
  localparam logic [3:0]  DIGIT_MAX  = 4'h9;
  localparam logic [3:0]  SIGN_MIN   = 4'ha;
  localparam logic [3:0]  SIGN_NEG_A = 4'hb;
  localparam logic [3:0]  SIGN_NEG_B = 4'hd;

  // ****************************************************************
  // Operations that touch the condition register
  // ****************************************************************
  typedef enum logic [3:0] {
    OP_ADD,
    OP_SUB,
    OP_DIVIDE,
    OP_ZERO_ADD,
    OP_DEC_ADD,
    OP_DEC_SUB,
    OP_CMP_BYTE,
    OP_CMP_SIGNED,
    OP_CMP_WORD
  } cfd_op_t;

endpackage : cfd_pkg

// *** cfd_dec_if.sv ***
`timescale 1ns/1ps
interface cfd_dec_if #(
  parameter int unsigned DIGITS = cfd_pkg::DIGITS_DEF
);
  localparam int unsigned PW = 8 * (DIGITS / 2 + 1);

  logic [8*DIGITS-1:0] zoned;
  logic [PW-1:0]       packed_val;
  logic                invalid;
  logic                negative;
  logic                zero;

  modport unit (input zoned, output packed_val, output invalid, output negative, output zero);
  modport user (output zoned, input packed_val, input invalid, input negative, input zero);
endinterface : cfd_dec_if

// *** cfd_zoned_pack.sv ***
`timescale 1ns/1ps
module cfd_zoned_pack
  import cfd_pkg::*;
#(
  parameter int unsigned DIGITS = DIGITS_DEF
) (
  cfd_dec_if.unit dec
);

  localparam int unsigned PW = 8 * (DIGITS / 2 + 1);

  logic [DIGITS-1:0]         dig_bad;
  logic [DIGITS-1:0]         dig_nz;
  logic [4*(DIGITS+1)-1:0]   pack_nib;
  logic [3:0]                sign_nib;

  // ****************************************************************
  // Per-digit check and packing; byte 0 is the least significant
  // ****************************************************************
  for (genvar i = 0; i < DIGITS; i++) begin : g_dig
    logic [3:0] digit;
    logic [3:0] zone;
    assign digit = dec.zoned[8*i +: 4];
    assign zone  = dec.zoned[8*i+4 +: 4];
    // Zone must be F except in the sign byte
    assign dig_bad[i] = (digit > DIGIT_MAX) || ((i != 0) && (zone != ZONE_NIB)); // RQ5 RQ21
    assign dig_nz[i]  = (digit != 4'h0);
    // Zone dropped, digit moves up one nibble to make room for the sign
    assign pack_nib[4*(i+1) +: 4] = digit; // RQ22
  end

  // Sign nibble rides in the zone of the lowest byte
  assign sign_nib       = dec.zoned[NIB_W +: 4];
  assign pack_nib[3:0]  = sign_nib; // RQ22
  assign dec.invalid    = (|dig_bad) || (sign_nib < SIGN_MIN); // RQ5
  assign dec.negative   = (sign_nib == SIGN_NEG_A) || (sign_nib == SIGN_NEG_B); // RQ21
  assign dec.zero       = ~(|dig_nz);
  // Even digit count leaves a zero leading nibble after extension
  assign dec.packed_val = PW'(pack_nib); // RQ22

endmodule : cfd_zoned_pack

// *** cfd_store_model.sv ***
`timescale 1ns/1ps
// ****************************************************************
// Storage word model seen by the flag unit
// ****************************************************************
module cfd_store_model (
  input  wire logic [15:0] mem_addr,
  output logic      [15:0] mem_word
);
  // Word lookup ignores the low address bit; the two bytes always differ so a swap shows
  assign mem_word = {mem_addr[8:1], ~mem_addr[8:1]};
endmodule : cfd_store_model

// *** tb_condition_flag_datapath.sv ***
`timescale 1ns/1ps
module tb_condition_flag_datapath;
  import cfd_pkg::*;
  localparam int unsigned DG = 4;  // Even digit count exercises the leading zero nibble
  typedef struct {int st; int sel; logic [31:0] v; logic [31:0] m;} cfd_exp_t;

  // ****************************************************************
  // Stimulus, outputs and scoreboard
  // ****************************************************************
  logic            clk = 0, reset_n = 0, op_valid = 0, op_double = 0;
  logic            div_overflow = 0, dec_lost = 0, flags_load = 0;
  logic            bound_violation = 0, service_request = 0;
  logic            read_parity_error = 0, illegal_opcode = 0;
  cfd_op_t         op_code = OP_ADD;
  logic [31:0]     opnd_a = 0, opnd_b = 0, arith_result;
  logic [8*DG-1:0] dec_zoned = 0;
  logic [15:0]     flags_load_data = 0, mem_addr = 0, mem_word, condition_flags, word_addr;
  logic [7:0]      byte_operand;
  logic [23:0]     packed_field;
  logic [15:0]     ef = 0;
  int              cyc = 0, fails = 0, total_checks = 0;
  integer          seed = 32'hf5c5;
  cfd_exp_t        q[$];

  cfd_flag_unit #(.DIGITS(DG)) dut (
    .clk, .reset_n, .op_valid, .op_code, .op_double, .opnd_a, .opnd_b, .div_overflow,
    .dec_lost, .dec_zoned, .bound_violation, .service_request, .read_parity_error,
    .illegal_opcode, .flags_load, .flags_load_data, .mem_addr, .mem_word,
    .condition_flags, .arith_result, .word_addr, .byte_operand, .packed_field
  );
  cfd_store_model store (.mem_addr, .mem_word);

  // Clock and cycle stamp for the scoreboard
  initial begin
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : finish_test

  task automatic chk(logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t output mismatch seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Note an expected value for the edge that samples the current request
  task automatic want(int sel, logic [31:0] v, logic [31:0] m = 32'hffffffff);
    q.push_back('{cyc + 1, sel, v, m});
  endtask : want

  // One request per call, every input but mem_addr set once just after the edge
  task automatic drive(logic v, cfd_op_t c, logic [31:0] a = 0, logic [31:0] b = 0,
                       logic d = 0, logic x = 0, logic [31:0] z = 0, logic [3:0] ev = 0,
                       logic ld = 0, logic [15:0] lv = 0);
    @(posedge clk);
    #2;
    op_valid = v;
    op_code = c;
    opnd_a = a;
    opnd_b = b;
    op_double = d;
    div_overflow = x;
    dec_lost = x;
    dec_zoned = z;
    {illegal_opcode, read_parity_error, service_request, bound_violation} = ev;
    flags_load = ld;
    flags_load_data = lv;
  endtask : drive

  task automatic arith(logic sub, logic d, logic [31:0] a, logic [31:0] b);
    logic [32:0] s;
    logic [31:0] bb;
    int          t;
    bb = sub ? ~b : b;
    t = d ? 31 : 15;
    if (d) s = {1'b0, a} + {1'b0, bb} + 33'(sub);
    else s = 33'({1'b0, a[15:0]} + {1'b0, bb[15:0]} + 17'(sub));
    drive(1, sub ? OP_SUB : OP_ADD, a, b, d);
    ef[3:0] = {s[t+1], 2'b00, (a[t] == bb[t]) && (s[t] != a[t])};
    want(0, ef);
    want(1, d ? s[31:0] : {16'h0, s[15:0]});
  endtask : arith

  task automatic cmp(cfd_op_t c, logic [31:0] a, logic [31:0] b);
    logic [31:0] sa, sb, ua, ub;
    sa = a;
    sb = b;
    ua = a ^ 32'h80000000;
    ub = b ^ 32'h80000000;
    if (c == OP_CMP_BYTE) begin
      {sa, sb, ua, ub} = {{24'h0, a[7:0]}, {24'h0, b[7:0]}, {24'h0, a[7:0]}, {24'h0, b[7:0]}};
    end else if (c == OP_CMP_WORD) begin
      {sa, sb} = {{{16{a[15]}}, a[15:0]}, {{16{b[15]}}, b[15:0]}};
      {ua, ub} = {{16'h0, a[15:0]}, {16'h0, b[15:0]}};
    end
    drive(1, c, a, b);
    ef[3:0] = {sa == sb, $signed(sa) < $signed(sb), $signed(sa) > $signed(sb), 1'b0};
    ef[7:4] = {ua == ub, ua < ub, ua > ub, 1'b0};
    want(0, ef);
  endtask : cmp

  task automatic dec(cfd_op_t c, logic [31:0] z, logic x, logic [7:0] lo, logic [7:0] m,
                     logic [23:0] p);
    drive(1, c, 0, 0, 0, x, z);
    ef[7:0] = lo;
    want(0, ef, {24'h00ff, m});
    if (m == 8'hff) want(2, p);
  endtask : dec

  // ****************************************************************
  // Scoreboard, storage traffic and watchdog
  // ****************************************************************
  initial begin
    cfd_exp_t    e;
    logic [31:0] s;
    forever begin
      @(posedge clk);
      #1;
      while (q.size() > 0 && q[0].st <= cyc) begin
        e = q.pop_front();
        case (e.sel)
          0: s = condition_flags;
          1: s = arith_result;
          2: s = packed_field;
          3: s = byte_operand;
          default: s = word_addr;
        endcase
        chk(s & e.m, e.v & e.m);
      end
    end
  end

  // Random storage addresses every cycle, alongside the operations
  initial begin
    logic [15:0] ma;
    wait (reset_n);
    forever begin
      @(posedge clk);
      #2;
      ma = $random(seed);
      mem_addr = ma;
      want(3, 8'(ma[0] ? ~ma[8:1] : ma[8:1]));
      want(4, {ma[15:1], 1'b0});
    end
  end

  // Whole run is about a hundred cycles; this limit is far beyond it
  initial begin
    #(25 * 6000);
    fails++;
    finish_test();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    logic [31:0] ra, rb;
    logic        rs, rd;
    cfd_op_t     ks[3];
    ks = '{OP_CMP_BYTE, OP_CMP_SIGNED, OP_CMP_WORD};
    repeat (20) @(posedge clk);
    #2;
    reset_n = 1;
    for (int i = 0; i < 4; i++) want(i, 0);
    // Each event alone, then all at once
    for (int i = 0; i < 5; i++) begin
      drive(0, OP_ADD, 0, 0, 0, 0, 0, (i == 4) ? 4'hf : 4'(1 << i));
      ef[15:12] = (i == 4) ? 4'hf : 4'(1 << i);
      want(0, ef);
    end
    // Restore; the reserved group never takes a value
    drive(0, OP_ADD, 0, 0, 0, 0, 0, 0, 1, 16'hffff);
    ef = 16'hf0ff;
    want(0, ef);
    drive(0, OP_ADD, 0, 0, 0, 0, 0, 0, 1, 16'h5a3c);
    ef = 16'h503c;
    want(0, ef);
    // Directed boundary sums and differences, then random ones and divides
    arith(0, 0, 32'h6f16, 32'h29b3);
    arith(0, 0, 32'h7fff, 32'h8000);
    arith(0, 0, 32'hffff, 32'h0001);
    arith(1, 0, 32'h7fff, 32'hffff);
    arith(1, 0, 32'h0005, 32'h0003);
    arith(0, 1, 32'h7fffffff, 32'h1);
    arith(1, 1, 32'h80000000, 32'h1);
    for (int i = 0; i < 24; i++) begin
      ra = $random(seed);
      rb = $random(seed);
      rs = ra[20];
      rd = rb[20];
      arith(rs, rd, rd ? ra : {16'h0, ra[15:0]}, rd ? rb : {16'h0, rb[15:0]});
    end
    drive(1, OP_DIVIDE, 32'h1, 32'h0, 0, 1);
    ef[3:0] = 4'b0001;
    want(0, ef);
    drive(1, OP_DIVIDE, 32'h8, 32'h2);
    ef[3:0] = 4'b0000;
    want(0, ef);
    // Every sign code, a zero result, faulty fields, then lost digits
    for (int s = 10; s < 16; s++) begin
      dec((s & 1) ? OP_DEC_SUB : OP_DEC_ADD, {24'hf8f6f3, 4'(s), 4'h4}, 0,
          (s == 11 || s == 13) ? 8'h44 : 8'h22, 8'hff, {20'h08634, 4'(s)});
    end
    dec(OP_DEC_ADD, 32'hf0f0f0c0, 0, 8'h88, 8'hff, 24'h00000c);
    dec(OP_DEC_ADD, 32'hf8faf3a4, 0, 8'h10, 8'h10, 0);
    dec(OP_DEC_SUB, 32'hf8f6f354, 0, 8'h10, 8'h10, 0);
    dec(OP_ZERO_ADD, 32'hf0f0f1c2, 1, 8'h01, 8'h01, 0);
    // Compares: equal, sign against magnitude, then random per kind
    cmp(OP_CMP_WORD, 32'h5, 32'h5);
    cmp(OP_CMP_WORD, 32'hffff, 32'h1);
    cmp(OP_CMP_BYTE, 32'hff, 32'h1);
    cmp(OP_CMP_SIGNED, 32'hffffffff, 32'h1);
    for (int i = 0; i < 24; i++) begin
      ra = $random(seed);
      rb = $random(seed);
      cmp(ks[i % 3], ra, ra[3] ? ra : rb);
    end
    // Event and restore together: the event owns its group
    drive(0, OP_ADD, 0, 0, 0, 0, 0, 4'b0010, 1, 16'h5a3c);
    ef = 16'h203c;
    want(0, ef);
    drive(0, OP_ADD);
    repeat (3) @(posedge clk);
    finish_test();
  end
endmodule : tb_condition_flag_datapath
